// *** verilog/acsc_top.sv ***
// Converter sequencer control: Wishbone registers, prescaler and sample sequencer
`timescale 1ns/1ps
module acsc_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   event_i,
  input  wire logic                   wake_i,
  input  wire acsc_pkg::acsc_fe_res_t fe_res_i,
  output acsc_pkg::acsc_fe_ctl_t      fe_ctl_o,
  output logic                        result_irq_o,
  output logic                        window_irq_o
);
  import acsc_pkg::*;

  acsc_state_rec_t s_q;
  acsc_state_rec_t s_d;

  logic        tick;
  logic        wr;
  logic        rd;
  logic        launch;
  logic        start;
  logic [4:0]  idx;
  logic        mapped;
  logic [15:0] sample_val;
  logic [15:0] acc_sum;

  // Divider limit: code c divides by 2 << c
  function automatic logic [7:0] div_lim(input logic [2:0] c);
    logic [8:0] d;
    d = DIV_BASE << c;
    return 8'(d - 9'h001);
  endfunction

  // Startup cycles; reserved codes give no wait
  function automatic logic [8:0] startup_cycles(input logic [2:0] c);
    logic [8:0] r;
    r = 9'h000;
    if (c != 3'h0 && c <= STARTUP_MAX) begin
      r = STARTUP_BASE << (c - 3'h1);
    end
    return r;
  endfunction

  // Number of samples per measurement; reserved code acts as none
  function automatic logic [6:0] acc_samples(input logic [2:0] c);
    logic [6:0] r;
    r = 7'h01;
    if (c != 3'h0 && c <= ACC_MAX) begin
      r = 7'h01 << c;
    end
    return r;
  endfunction

  // Window match on the final result
  function automatic logic win_hit(input logic [2:0] m, input logic [15:0] v,
                                   input logic [15:0] lo, input logic [15:0] hi);
    logic h;
    case (m)
      WIN_BELOW:   h = v < lo;
      WIN_ABOVE:   h = v > hi;
      WIN_INSIDE:  h = (v > lo) && (v < hi);
      WIN_OUTSIDE: h = (v < lo) || (v > hi);
      default:     h = 1'b0;
    endcase
    return h;
  endfunction

  // Read decode, used by the read mux only
  function automatic logic [31:0] rd_word(input logic [4:0] i, input acsc_state_rec_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      IDX_CTRL_MAIN: begin
        w[POS_ENABLE] = s.enable;
        w[POS_RESOLUTION_CHOICE] = s.resolution_choice;
      end
      IDX_ACCUM:      w[2:0] = s.accumulation_count;
      IDX_CLOCK_REF: begin
        w[POS_REFERENCE_CHOICE+:2] = s.reference_choice;
        w[2:0] = s.clock_divider_code;
      end
      IDX_TIMING: begin
        w[POS_STARTUP+:3] = s.startup_wait;
        w[POS_AUTO_DELAY_VARIATION] = s.auto_delay_variation;
        w[3:0] = s.inter_sample_wait;
      end
      IDX_WINDOW:     w[2:0] = s.window_compare_mode;
      IDX_SAMPLE_LEN: w[4:0] = s.sampling_extension;
      IDX_INPUT_SEL:  w[4:0] = s.input_channel_code;
      IDX_COMMAND:    w[POS_LAUNCH] = (s.st != ST_IDLE);
      IDX_EVENT:      w[POS_EVT_EN] = s.event_launch_enable;
      IDX_INT_EN:     w[1:0] = s.int_enable;
      IDX_INT_FLAGS:  w[1:0] = s.int_flags;
      IDX_RESULT:     w[15:0] = s.result;
      IDX_WIN_LOW:    w[15:0] = s.window_low_threshold;
      IDX_WIN_HIGH:   w[15:0] = s.window_high_threshold;
      default:        w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    idx = wb_adr_i[6:2];
    mapped = (wb_adr_i[7] == 1'b0);
    tick = (s_q.div_cnt == div_lim(s_q.clock_divider_code));
    s_d.div_cnt = tick ? 8'h00 : s_q.div_cnt + 8'h01;
    s_d.convert = 1'b0;
    launch = 1'b0;
    // Ack one cycle after the request; the write lands on the acked edge
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack & mapped;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & s_q.ack & mapped;
    if (s_d.ack) begin
      s_d.rdata = mapped ? rd_word(idx, s_q) : 32'h0000_0000;
    end
    sample_val = s_q.resolution_choice ? {8'h00, fe_res_i.data[9:2]}
                                       : {6'h00, fe_res_i.data};
    acc_sum = s_q.acc + sample_val;

    // Register writes; only byte lane 0 unless a 16-bit register
    if (wr && wb_sel_i[0]) begin
      case (idx)
        IDX_CTRL_MAIN: begin
          if (wb_dat_i[POS_ENABLE] && !s_q.enable) begin
            s_d.init_pending = 1'b1;
          end
          s_d.enable = wb_dat_i[POS_ENABLE];
          s_d.resolution_choice = wb_dat_i[POS_RESOLUTION_CHOICE];
        end
        IDX_ACCUM:      s_d.accumulation_count = wb_dat_i[2:0];
        IDX_CLOCK_REF: begin
          if (wb_dat_i[POS_REFERENCE_CHOICE+:2] == REF_INTERNAL && s_q.reference_choice != REF_INTERNAL) begin
            s_d.init_pending = 1'b1;
          end
          s_d.reference_choice = wb_dat_i[POS_REFERENCE_CHOICE+:2];
          s_d.clock_divider_code = wb_dat_i[2:0];
        end
        IDX_TIMING: begin
          s_d.startup_wait = wb_dat_i[POS_STARTUP+:3];
          s_d.auto_delay_variation = wb_dat_i[POS_AUTO_DELAY_VARIATION];
          s_d.inter_sample_wait = wb_dat_i[3:0];
        end
        IDX_WINDOW:     s_d.window_compare_mode = wb_dat_i[2:0];
        IDX_SAMPLE_LEN: s_d.sampling_extension = wb_dat_i[4:0];
        IDX_INPUT_SEL:  s_d.input_channel_code = wb_dat_i[4:0];
        IDX_COMMAND:    launch = wb_dat_i[POS_LAUNCH];
        IDX_EVENT:      s_d.event_launch_enable = wb_dat_i[POS_EVT_EN];
        IDX_INT_EN:     s_d.int_enable = wb_dat_i[1:0];
        IDX_INT_FLAGS:  s_d.int_flags = s_q.int_flags & ~wb_dat_i[1:0];
        IDX_WIN_LOW:    s_d.window_low_threshold[7:0] = wb_dat_i[7:0];
        IDX_WIN_HIGH:   s_d.window_high_threshold[7:0] = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
    if (wr && wb_sel_i[1]) begin
      if (idx == IDX_WIN_LOW) begin
        s_d.window_low_threshold[15:8] = wb_dat_i[15:8];
      end
      if (idx == IDX_WIN_HIGH) begin
        s_d.window_high_threshold[15:8] = wb_dat_i[15:8];
      end
    end
    // Reading the result clears both flags
    if (rd && idx == IDX_RESULT) begin
      s_d.int_flags = 2'b00;
    end
    if (wake_i) begin
      s_d.init_pending = 1'b1;
    end

    // A start is taken only from idle, so a busy sequencer is never disturbed
    start = (launch | (event_i & s_q.event_launch_enable))
            & s_q.enable & (s_q.st == ST_IDLE);

    case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          s_d.active_channel = s_d.input_channel_code;
          s_d.acc = 16'h0000;
          s_d.left = acc_samples(s_q.accumulation_count);
          if (s_d.init_pending) begin
            s_d.init_pending = 1'b0;
            s_d.cnt = startup_cycles(s_q.startup_wait);
            s_d.st = ST_STARTUP;
          end else begin
            s_d.cnt = SAMPLE_BASE + {4'h0, s_q.sampling_extension};
            s_d.st = ST_SAMPLE;
          end
        end
      end
      ST_STARTUP: begin
        if (s_q.cnt == 9'h000) begin
          s_d.cnt = SAMPLE_BASE + {4'h0, s_q.sampling_extension};
          s_d.st = ST_SAMPLE;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
        end
      end
      ST_SAMPLE: begin
        if (s_q.cnt == 9'h000) begin
          s_d.convert = 1'b1;
          s_d.st = ST_CONVERT;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
        end
      end
      ST_CONVERT: begin
        if (fe_res_i.valid) begin
          s_d.acc = acc_sum;
          s_d.left = s_q.left - 7'h01;
          if (s_q.auto_delay_variation) begin
            s_d.inter_sample_wait = s_q.inter_sample_wait + 4'h1;
          end
          if (s_q.left == 7'h01) begin
            // Final value: flags set here win over a clear in the same cycle
            s_d.result = acc_sum;
            s_d.int_flags[POS_RESULT] = 1'b1;
            if (win_hit(s_q.window_compare_mode, acc_sum, s_q.window_low_threshold,
                        s_q.window_high_threshold)) begin
              s_d.int_flags[POS_WINDOW] = 1'b1;
            end
            s_d.st = ST_IDLE;
          end else begin
            s_d.cnt = {5'h00, s_q.inter_sample_wait};
            s_d.st = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (s_q.cnt == 9'h000) begin
          s_d.cnt = SAMPLE_BASE + {4'h0, s_q.sampling_extension};
          s_d.st = ST_SAMPLE;
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Disabling aborts a running sequence
    if (!s_d.enable) begin
      s_d.st = ST_IDLE;
      s_d.convert = 1'b0;
    end
    // New selection reaches the mux only once the sequencer is idle
    if (s_d.st == ST_IDLE) begin
      s_d.active_channel = s_d.input_channel_code;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; interrupt lines gate flags with enables
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign fe_ctl_o.reference_choice = s_q.reference_choice;
  assign fe_ctl_o.input_channel_code = s_q.active_channel;
  assign fe_ctl_o.sample_hold = (s_q.st == ST_SAMPLE); // Cap open in gap
  assign fe_ctl_o.convert = s_q.convert;
  assign result_irq_o = s_q.int_enable[POS_RESULT] & s_q.int_flags[POS_RESULT];
  assign window_irq_o = s_q.int_enable[POS_WINDOW] & s_q.int_flags[POS_WINDOW];
endmodule

// *** verilog/acsc_pkg.sv ***
// Constants, types and state record of the converter sequencer control block
// Function
// - Two-bit reference field: 0 internal reference, 1 supply, others reserved.
// - Converter clock is the peripheral clock divided by 2 to 256 per code.
// - Startup wait of 0 to 256 converter cycles before first sample after enable or a switch to the internal reference.
// - Startup wait also applies after a deep-sleep wake for a measurement.
// - With auto delay variation, inter-sample wait field increments after every sample.
// - Auto-incremented inter-sample wait wraps from 0xF to 0x0.
// - Gap between consecutive samples equals the wait field in converter cycles, cap open.
// - Result compared to low/high thresholds per three-bit window mode.
// - Sampling lasts two converter cycles plus the five-bit extension field.
// - Five-bit code selects pins 0 to 11, internal reference 0x1D or ground 0x1F.
// - Input selection rewritten mid-conversion takes effect only after that conversion.
// - Writing one to command bit 0 launches a single measurement.
// - Launch bit reads one while converting and clears itself at completion.
// - Event enable bit 0 lets the event input start a conversion.
// - Each interrupt line is high only while its enable and flag are both set.
// - At conversion end, window flag bit 1 sets when the result meets the mode.
// - Window flag clears by writing one or reading the result; zero does nothing.
// - Result flag bit 0 sets whenever a measurement completes.
// - Result flag clears by writing one or reading the result; zero does nothing.
// - Accumulation field codes 1 to 6 sum 2 to 64 samples; 0 none, 7 reserved.
// - Window thresholds apply to the final accumulated value.
// - Reduced resolution keeps the eight upper bits of each sample.
package acsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL_MAIN  = 5'h00;
  localparam logic [4:0] IDX_ACCUM      = 5'h01;
  localparam logic [4:0] IDX_CLOCK_REF  = 5'h02;
  localparam logic [4:0] IDX_TIMING     = 5'h03;
  localparam logic [4:0] IDX_WINDOW     = 5'h04;
  localparam logic [4:0] IDX_SAMPLE_LEN = 5'h05;
  localparam logic [4:0] IDX_INPUT_SEL  = 5'h06;
  localparam logic [4:0] IDX_COMMAND    = 5'h08;
  localparam logic [4:0] IDX_EVENT      = 5'h09;
  localparam logic [4:0] IDX_INT_EN     = 5'h0a;
  localparam logic [4:0] IDX_INT_FLAGS  = 5'h0b;
  localparam logic [4:0] IDX_RESULT     = 5'h10;
  localparam logic [4:0] IDX_WIN_LOW    = 5'h12;
  localparam logic [4:0] IDX_WIN_HIGH   = 5'h14;
  // Field positions
  localparam int POS_ENABLE    = 0;
  localparam int POS_RESOLUTION_CHOICE    = 2;
  localparam int POS_REFERENCE_CHOICE    = 4;
  localparam int POS_STARTUP   = 5;
  localparam int POS_AUTO_DELAY_VARIATION      = 4;
  localparam int POS_LAUNCH    = 0;
  localparam int POS_EVT_EN    = 0;
  localparam int POS_RESULT    = 0;
  localparam int POS_WINDOW    = 1;
  // Codes and timing counts, in converter clock cycles
  localparam logic [1:0] REF_INTERNAL   = 2'h0;
  localparam logic [1:0] REF_SUPPLY     = 2'h1;
  localparam logic [2:0] WIN_NONE       = 3'h0;
  localparam logic [2:0] WIN_BELOW      = 3'h1;
  localparam logic [2:0] WIN_ABOVE      = 3'h2;
  localparam logic [2:0] WIN_INSIDE     = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE    = 3'h4;
  localparam logic [2:0] STARTUP_MAX    = 3'h5;
  localparam logic [2:0] ACC_MAX        = 3'h6;
  localparam logic [8:0] STARTUP_BASE   = 9'h010;
  localparam logic [8:0] SAMPLE_BASE    = 9'h002;
  localparam logic [8:0] DIV_BASE       = 9'h002;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // Gray-coded sequencer states along idle, startup, sample, convert, gap
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_STARTUP = 3'b001,
    ST_SAMPLE  = 3'b011,
    ST_CONVERT = 3'b010,
    ST_GAP     = 3'b110
  } acsc_state_t;

  // Controls toward the analog front end
  typedef struct packed {
    logic [1:0] reference_choice;
    logic [4:0] input_channel_code;
    logic       sample_hold;
    logic       convert;
  } acsc_fe_ctl_t;

  // Sample returned by the analog front end
  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } acsc_fe_res_t;

  // Whole state of the block
  typedef struct packed {
    acsc_state_t st;
    logic [7:0]  div_cnt;
    logic [8:0]  cnt;
    logic [6:0]  left;
    logic [15:0] acc;
    logic [15:0] result;
    logic        enable;
    logic        resolution_choice;
    logic [2:0]  accumulation_count;
    logic [1:0]  reference_choice;
    logic [2:0]  clock_divider_code;
    logic [2:0]  startup_wait;
    logic        auto_delay_variation;
    logic [3:0]  inter_sample_wait;
    logic [2:0]  window_compare_mode;
    logic [4:0]  sampling_extension;
    logic [4:0]  input_channel_code;
    logic [4:0]  active_channel;
    logic        event_launch_enable;
    logic [1:0]  int_enable;
    logic [1:0]  int_flags;
    logic [15:0] window_low_threshold;
    logic [15:0] window_high_threshold;
    logic        init_pending;
    logic        convert;
    logic        ack;
    logic [31:0] rdata;
  } acsc_state_rec_t;
endpackage

// *** verification/acsc_props.sv ***
// Port-level checks of the converter sequencer control block
`timescale 1ns/1ps
module acsc_props (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   event_i,
  input wire logic                   wake_i,
  input wire acsc_pkg::acsc_fe_res_t fe_res_i,
  input wire acsc_pkg::acsc_fe_ctl_t fe_ctl_o,
  input wire logic                   result_irq_o,
  input wire logic                   window_irq_o
);
  import acsc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers exactly one cycle after a new request and only once
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without request");
  // Interrupt lines follow their enables; flags clear by write of one or result read
  AST_RES_MASK: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h28 && wb_sel_i[0]
    && !wb_dat_i[0] |=> !result_irq_o)
    else $error("result irq high while disabled");
  AST_WIN_MASK: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h28 && wb_sel_i[0]
    && !wb_dat_i[1] |=> !window_irq_o)
    else $error("window irq high while disabled");
  // A completion in the clearing cycle sets the flags again, so that cycle is left out
  AST_W1C: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h2c && wb_sel_i[0]
    && wb_dat_i[1:0] == 2'h3 && !fe_res_i.valid |=> !result_irq_o && !window_irq_o)
    else $error("flags not cleared by write of one");
  AST_READ_CLR: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40
    && !fe_res_i.valid |=> !result_irq_o && !window_irq_o)
    else $error("flags not cleared by result read");
  // Sampling lasts at least three clocks and the channel is frozen meanwhile
  AST_SAMPLE_MIN: assert property ($rose(fe_ctl_o.sample_hold) |-> fe_ctl_o.sample_hold[*3])
    else $error("sampling phase too short");
  AST_CHAN_HOLD: assert property (fe_ctl_o.sample_hold && $past(fe_ctl_o.sample_hold)
    |-> $stable(fe_ctl_o.input_channel_code))
    else $error("channel changed during sampling");
  AST_CONV_PULSE: assert property (fe_ctl_o.convert |=> !fe_ctl_o.convert)
    else $error("convert longer than one clock");
endmodule

// *** verification/acsc_fe_model.sv ***
// Behavioural analog front end answering each convert pulse with one sample
`timescale 1ns/1ps
module acsc_fe_model (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire acsc_pkg::acsc_fe_ctl_t fe_ctl_i,
  input  wire logic [9:0]             sample_i,
  output acsc_pkg::acsc_fe_res_t      fe_res_o
);
  import acsc_pkg::*;
  logic [2:0] wait_q;
  // Answer after 1 to 4 clocks; data is scrambled outside the valid cycle so stale bits never match
  always @(posedge clk_i) begin
    fe_res_o.valid <= 1'b0;
    fe_res_o.data  <= rst_i ? 10'h155 : ~fe_res_o.data;
    if (rst_i) wait_q <= 3'h0;
    else if (fe_ctl_i.convert) wait_q <= 3'(1 + $urandom % 4);
    else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
      if (wait_q == 3'h1) begin
        fe_res_o.valid <= 1'b1;
        fe_res_o.data  <= sample_i;
      end
    end
  end
endmodule

// *** verification/acsc_top_test.sv ***
// Self-checking bench of the converter sequencer control block
`timescale 1ns/1ps
module acsc_top_test;
  import acsc_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [3:0]   wb_sel_i = 4'h3;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, rd;
  logic         wb_ack_o, result_irq_o, window_irq_o, event_i = 1'b0, wake_i = 1'b0;
  logic [9:0]   smp = 10'h000;
  logic [2:0]   mode = 3'h0;
  logic [15:0]  lo = 16'h0100, hi = 16'h0300;
  acsc_fe_res_t fe_res_i;
  acsc_fe_ctl_t fe_ctl_o;
  int           num_errors = 0, num_checks = 0, hold = 0, dt, dh, e;
  // Register places in read-back order and their writable bits
  logic [7:0]   regs [8] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [7:0]   msk [8] = '{8'hff, 8'h07, 8'h1f, 8'h1f, 8'h00, 8'h01, 8'h03, 8'h00};
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Clocks spent in the sampling phase
  always @(posedge clk_i) begin
    if (fe_ctl_o.sample_hold) hold <= hold + 1;
  end
  acsc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_i(event_i), .wake_i(wake_i), .fe_res_i(fe_res_i), .fe_ctl_o(fe_ctl_o),
    .result_irq_o(result_irq_o), .window_irq_o(window_irq_o));
  acsc_fe_model i_fe (.clk_i(clk_i), .rst_i(rst_i), .fe_ctl_i(fe_ctl_o), .sample_i(smp), .fe_res_o(fe_res_i));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20) chk(32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic win(input logic [2:0] m, input logic [15:0] r);
    case (m)
      WIN_BELOW: win = r < lo;
      WIN_ABOVE: win = r > hi;
      WIN_INSIDE: win = r > lo && r < hi;
      WIN_OUTSIDE: win = r < lo || r > hi;
      default: win = 1'b0;
    endcase
  endfunction
  // One measurement by event or command; event runs clear flags by write, command runs by result read
  task automatic conv(input logic ev, input logic [15:0] exp);
    int n;
    logic [4:0] ch;
    n = 0;
    ch = 5'($urandom % 12);
    dt = int'($time);
    dh = hold;
    if (ev) begin
      @(posedge clk_i);
      event_i <= 1'b1;
      @(posedge clk_i);
      event_i <= 1'b0;
    end else begin
      wb(1'b1, 8'h20, 32'h1);
      wb(1'b0, 8'h20, 32'h0);
      chk(rd[0], 1'b1);
      wb(1'b1, 8'h18, {27'h0, ch});
      wb(1'b1, 8'h20, 32'h1);
    end
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 2000) begin
      wb(1'b0, 8'h2c, 32'h0);
      n++;
    end
    dt = (int'($time) - dt) / 5;
    dh = hold - dh;
    chk(rd[1:0], {win(mode, exp), 1'b1});
    chk({window_irq_o, result_irq_o}, {win(mode, exp), 1'b1});
    wb(1'b1, 8'h2c, 32'h0);
    wb(1'b0, 8'h2c, 32'h0);
    chk(rd[1:0], {win(mode, exp), 1'b1});
    if (ev) wb(1'b1, 8'h2c, 32'h3);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd[15:0], exp);
    wb(1'b0, 8'h2c, 32'h0);
    chk(rd[1:0], 2'h0);
    if (!ev) begin
      wb(1'b0, 8'h20, 32'h0);
      chk({rd[0], fe_ctl_o.input_channel_code}, {1'b0, ch});
    end
  endtask
  initial begin
    logic [31:0] v;
    void'($urandom(32'ha673));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place, then random write and read back
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0);
      chk(rd[7:0], 8'h00);
    end
    wb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
    foreach (regs[i]) begin
      v = $urandom;
      if (msk[i] != 8'h00) wb(1'b1, regs[i], v);
      wb(1'b0, regs[i], 32'h0);
      chk(rd[7:0], v[7:0] & msk[i]);
    end
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h14, 32'h8);
    wb(1'b1, 8'h48, {16'h0, lo});
    wb(1'b1, 8'h50, {16'h0, hi});
    wb(1'b1, 8'h18, 32'h0);
    wb(1'b1, 8'h28, 32'h3);
    wb(1'b1, 8'h00, 32'h1);
    // Every window mode against a random sample
    for (int m = 0; m < 5; m++) begin
      mode = 3'(m);
      wb(1'b1, 8'h10, 32'(m));
      smp = 10'($urandom);
      conv(1'b0, {6'h0, smp});
    end
    // Events ignored while disabled, accepted when enabled
    wb(1'b1, 8'h24, 32'h0);
    @(posedge clk_i);
    event_i <= 1'b1;
    @(posedge clk_i);
    event_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    wb(1'b0, 8'h2c, 32'h0);
    chk(rd[1:0], 2'h0);
    wb(1'b1, 8'h24, 32'h1);
    smp = 10'($urandom);
    conv(1'b1, {6'h0, smp});
    // Two-sample sums with auto delay wrapping, then reduced resolution
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h0c, 32'h1f);
    conv(1'b0, {5'h0, smp, 1'b0});
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd[7:0], 8'h11);
    wb(1'b1, 8'h00, 32'h5);
    conv(1'b0, {7'h0, smp[9:2], 1'b0});
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h0c, 32'h0);
    // Every divider code: sampling time is (2 + extension) converter ticks
    for (int c = 0; c < 8; c++) begin
      e = 8 + $urandom % 3;
      wb(1'b1, 8'h08, 32'h10 | c);
      wb(1'b1, 8'h14, 32'(e));
      smp = 10'($urandom);
      conv(1'b0, {6'h0, smp});
      chk(fe_ctl_o.reference_choice, REF_SUPPLY);
      chk(dh >= (1 + e) * (2 << c) + 2 && dh <= (2 + e) * (2 << c) + 1, 1'b1);
    end
    // Wake, then a switch to the internal reference, each arm a 256-tick startup wait
    wb(1'b1, 8'h08, 32'h10);
    wb(1'b1, 8'h0c, 32'ha0);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    conv(1'b0, {6'h0, smp});
    chk(dt >= 512, 1'b1);
    wb(1'b1, 8'h08, 32'h0);
    conv(1'b0, {6'h0, smp});
    chk(dt >= 512, 1'b1);
    chk(fe_ctl_o.reference_choice, REF_INTERNAL);
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule
bind acsc_top acsc_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .event_i(event_i), .wake_i(wake_i), .fe_res_i(fe_res_i), .fe_ctl_o(fe_ctl_o),
  .result_irq_o(result_irq_o), .window_irq_o(window_irq_o));
